// ===== bench/capture_regs_tb.sv
// self-checking bench for the capture configuration and status register bank
// assumes the one-cycle register port and one-cycle event pulses of capture_regs
module capture_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

    logic                         clk, rstn, wr_en, rd_en, rvalid;
    logic                         cur_field_even, field_toggle, i2c_ok, parity_resp_en;
    logic                         dma_set_enable, dma_clear_enable, dma_program_enable;
    logic                         blank_write_ok, video_write_ok, irq_n;
    logic [8:0]                   addr;
    logic [31:0]                  wdata, rdata;
    logic [3:0]                   instr_set, instr_clear;
    capture_regs_pkg::event_type  ev;
    capture_regs_pkg::config_type cfg;
    int                           failures, checked, cycles;
    logic [8:0]                   rst_addrs [10] = '{9'h0dc, 9'h0e0, 9'h0e4, 9'h0e8, 9'h0f0,
                                                     9'h0f4, 9'h0f8, 9'h100, 9'h104, 9'h0ec};

    capture_regs DUT (.clk(clk), .rstn(rstn), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wdata(wdata), .rdata(rdata), .rvalid(rvalid), .cur_field_even(cur_field_even),
        .field_toggle(field_toggle), .dma_set_enable(dma_set_enable),
        .dma_clear_enable(dma_clear_enable), .instr_set(instr_set), .instr_clear(instr_clear),
        .i2c_ok(i2c_ok), .parity_resp_en(parity_resp_en), .ev(ev), .cfg(cfg),
        .blank_write_ok(blank_write_ok), .video_write_ok(video_write_ok),
        .dma_program_enable(dma_program_enable), .irq_n(irq_n));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude

    // the whole sequence needs about a hundred cycles; a hang is stopped at the 3000-cycle budget
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            conclude();
        end
    end

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [8:0] a, input logic [31:0] exp);
        int n = 0;
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        while (rvalid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(rvalid, 1'b1)
        `CHK(rdata, exp)
        @(posedge clk);
    endtask : rd

    task automatic field_pulses(input int k);
        repeat (k) begin
            field_toggle <= 1'b1;
            @(posedge clk);
            field_toggle <= 1'b0;
            @(posedge clk);
        end
    endtask : field_pulses

    initial begin
        rstn = 1'b0; wr_en = 1'b0; rd_en = 1'b0; addr = 9'h000; wdata = 32'h0;
        cur_field_even = 1'b0; field_toggle = 1'b0; i2c_ok = 1'b0; parity_resp_en = 1'b0;
        dma_set_enable = 1'b0; dma_clear_enable = 1'b0; instr_set = 4'h0; instr_clear = 4'h0;
        ev = '0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 10; i++) rd(rst_addrs[i], 32'h0);
        #1;
        `CHK(irq_n, 1'b1)
        @(posedge clk);
        // control bits, reserved top bits and field gating
        wr(9'h0dc, 32'hffffffff);
        rd(9'h0dc, 32'h1f);
        `CHK(cfg.dither_full_frame, 1'b1)
        `CHK(blank_write_ok, 1'b1)
        `CHK(video_write_ok, 1'b1)
        wr(9'h0dc, 32'h0a);
        rd(9'h0dc, 32'h0a);
        `CHK(cfg.dither_full_frame, 1'b0)
        `CHK({blank_write_ok, video_write_ok}, 2'b11)
        cur_field_even <= 1'b1;
        @(posedge clk);
        #1;
        `CHK({blank_write_ok, video_write_ok}, 2'b00)
        @(posedge clk);
        // blanking length and delay, pll settings
        wr(9'h0e0, 32'ha5);
        wr(9'h0e4, 32'hff);
        rd(9'h0e4, 32'hff);
        `CHK(cfg.blank_length, 9'h1a5)
        `CHK(cfg.blank_line_delay, 6'h3f)
        `CHK(cfg.frame_region_extend, 1'b1)
        wr(9'h0e4, 32'h0e);
        rd(9'h0e0, 32'ha5);
        `CHK(cfg.blank_length, 9'h0a5)
        `CHK(cfg.blank_line_delay, 6'h03)
        wr(9'h0f0, 32'h34);
        wr(9'h0f4, 32'h12);
        wr(9'h0f8, 32'hc0);
        rd(9'h0f4, 32'h12);
        `CHK(cfg.pll_fraction, 16'h1234)
        `CHK({cfg.pll_sleep, cfg.pll_post_div_four, cfg.pll_pre_div_two}, 3'b111)
        wr(9'h0f8, 32'h06);
        rd(9'h0f8, 32'h06);
        `CHK({cfg.pll_sleep, cfg.pll_post_div_four, cfg.pll_pre_div_two}, 3'b000)
        `CHK(cfg.pll_integer, 6'h06)
        // field counter counts only while capturing, any write clears it
        field_pulses(3);
        rd(9'h0e8, 32'h03);
        wr(9'h0e8, 32'h55);
        rd(9'h0e8, 32'h00);
        wr(9'h0dc, 32'h10);
        field_pulses(2);
        rd(9'h0e8, 32'h00);
        // read-only status fields
        dma_set_enable <= 1'b1;
        instr_set      <= 4'h5;
        i2c_ok         <= 1'b1;
        @(posedge clk);
        dma_set_enable <= 1'b0;
        instr_set      <= 4'h0;
        i2c_ok         <= 1'b0;
        rd(9'h100, 32'h5b000000);
        `CHK(dma_program_enable, 1'b1)
        // every event at once; parity response enabled so the fetch flag latches
        parity_resp_en <= 1'b1;
        ev             <= '1;
        @(posedge clk);
        ev <= '0;
        rd(9'h100, 32'h510ffb3f);
        `CHK(dma_program_enable, 1'b0)
        `CHK(irq_n, 1'b1)
        wr(9'h104, 32'h1);
        rd(9'h104, 32'h1);
        `CHK(irq_n, 1'b0)
        wr(9'h100, 32'h000f0000);
        rd(9'h100, 32'h5100fb3f);
        `CHK(irq_n, 1'b0)
        wr(9'h100, 32'hffffffff);
        rd(9'h100, 32'h51000000);
        `CHK(irq_n, 1'b1)
        // fetch parity needs the response enable, bus parity does not
        parity_resp_en   <= 1'b0;
        ev.instr_parity  <= 1'b1;
        ev.bus_parity    <= 1'b1;
        instr_clear      <= 4'h1;
        dma_clear_enable <= 1'b1;
        @(posedge clk);
        ev               <= '0;
        instr_clear      <= 4'h0;
        dma_clear_enable <= 1'b0;
        rd(9'h100, 32'h41008000);
        wr(9'h0ec, 32'hff);
        rd(9'h0ec, 32'h0);
        conclude();
    end

endmodule : capture_regs_tb

// ===== logic/capture_regs.sv
// capture configuration, pll setting, field counter and interrupt status registers
// assumes a one-cycle register port: wr_en/rd_en strobes with byte offset,
// and one-cycle event pulses from the capture, dma, i2c and bus logic
//
// Contract
// RULE_01: dither bit selects field or frame scope
// RULE_02: blanking capture gated per field enable
// RULE_03: active video writes gated per field enable
// RULE_04: nine-bit blanking length split across registers
// RULE_05: six-bit delay after horizontal reset pulse
// RULE_06: extend bit adds ten lines before active
// RULE_07: sixteen-bit pll fraction, low byte first
// RULE_08: integer zero puts pll to sleep
// RULE_09: post divider six/four, pre divider one/two
// RULE_10: field counter counts transitions while capturing
// RULE_11: any counter write clears it
// RULE_12: write one clears latched status bits
// RULE_13: instruction status and dma enable read only
// RULE_14: ack bit set on success, cleared on nack
// RULE_15: field indicator odd zero, even one
// RULE_16: sync error latched on overflow or mismatch
// RULE_17: opcode error latched on instruction errors
// RULE_18: abort latched on master or target abort
// RULE_19: fetch parity latches flag, clears dma enable
// RULE_20: bus parity latched regardless of response
// RULE_21: resync and two overrun flags latched
// RULE_22: instruction, pin and i2c flags latched
// RULE_23: video event flags latched
// RULE_24: masked status drives level interrupt output
// RULE_25: reserved bits read zero, ignore writes
module capture_regs (
    input  wire logic        clk,              // 100 MHz bus clock
    input  wire logic        rstn,             // synchronous reset, active low
    input  wire logic        wr_en,            // register write strobe
    input  wire logic        rd_en,            // register read strobe
    input  wire logic [8:0]  addr,             // byte offset
    input  wire logic [31:0] wdata,            // write data
    output logic      [31:0] rdata,            // read data, registered
    output logic             rvalid,           // read data valid pulse
    input  wire logic        cur_field_even,   // current field, 1 = even
    input  wire logic        field_toggle,     // field transition pulse
    input  wire logic        dma_set_enable,   // software dma enable rise
    input  wire logic        dma_clear_enable, // dma controller stops
    input  wire logic [3:0]  instr_set,        // instruction status set bits
    input  wire logic [3:0]  instr_clear,      // instruction status reset bits
    input  wire logic        i2c_ok,           // i2c finished with ack
    input  wire logic        parity_resp_en,   // parity error response enable
    input  wire capture_regs_pkg::event_type ev, // event pulses
    output capture_regs_pkg::config_type cfg,  // decoded settings
    output logic             blank_write_ok,   // blanking capture allowed now
    output logic             video_write_ok,   // active video write allowed now
    output logic             dma_program_enable, // dma enable state
    output logic             irq_n             // level interrupt, active low
);

    logic [4:0]  ctl_reg;
    logic [7:0]  len_lo_reg;
    logic [7:0]  len_hi_reg;
    logic [7:0]  count_reg;
    logic [7:0]  frac_lo_reg;
    logic [7:0]  frac_hi_reg;
    logic [7:0]  pll_reg;
    logic [22:0] stat_reg;
    logic [22:0] stat_next;
    logic [22:0] mask_reg;
    logic [3:0]  instr_reg;
    logic        ack_reg;
    logic        dma_reg;
    logic [22:0] ev_vec;
    logic        fetch_parity;

    function automatic logic hit(input logic [8:0] a, input logic [8:0] off);
        hit = (a == off);
    endfunction : hit

    // map the event struct onto status bit positions
    always_comb begin
        ev_vec = '0;
        ev_vec[19] = ev.sync_error;                        // [RULE_16]
        ev_vec[18] = ev.opcode_error;                      // [RULE_17]
        ev_vec[17] = ev.bus_abort;                         // [RULE_18]
        ev_vec[16] = fetch_parity;                         // [RULE_19]
        ev_vec[15] = ev.bus_parity;                        // [RULE_20]
        ev_vec[14] = ev.stream_resync;                     // [RULE_21]
        ev_vec[13] = ev.overrun_latency;                   // [RULE_21]
        ev_vec[12] = ev.overrun_drop;                      // [RULE_21]
        ev_vec[11] = ev.instr_irq;                         // [RULE_22]
        ev_vec[9]  = ev.gp_pin;                            // [RULE_22]
        ev_vec[8]  = ev.i2c_done;                          // [RULE_22]
        ev_vec[5]  = ev.video_presence;                    // [RULE_23]
        ev_vec[4]  = ev.change_flag_a;                     // [RULE_23]
        ev_vec[3]  = ev.conv_overflow;                     // [RULE_23]
        ev_vec[2]  = ev.new_line;                          // [RULE_23]
        ev_vec[1]  = ev.field_change;                      // [RULE_23]
        ev_vec[0]  = ev.format_change;                     // [RULE_23]
    end

    // parity only counts against fetch when response is enabled
    assign fetch_parity = ev.instr_parity & parity_resp_en; // [RULE_19]

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctl_reg     <= '0;
            len_lo_reg  <= capture_regs_pkg::byte_reset;
            len_hi_reg  <= capture_regs_pkg::byte_reset;
            frac_lo_reg <= capture_regs_pkg::byte_reset;
            frac_hi_reg <= capture_regs_pkg::byte_reset;
            pll_reg     <= capture_regs_pkg::byte_reset;
            mask_reg    <= capture_regs_pkg::mask_reset;
        end else if (wr_en) begin
            if (hit(addr, capture_regs_pkg::capture_control_offset)) begin
                ctl_reg <= wdata[4:0];                     // [RULE_25]
            end
            if (hit(addr, capture_regs_pkg::vbi_length_low_offset)) begin
                len_lo_reg <= wdata[7:0];                  // [RULE_04]
            end
            if (hit(addr, capture_regs_pkg::vbi_length_high_delay_offset)) begin
                len_hi_reg <= wdata[7:0];                  // [RULE_05]
            end
            if (hit(addr, capture_regs_pkg::pll_fraction_low_offset)) begin
                frac_lo_reg <= wdata[7:0];                 // [RULE_07]
            end
            if (hit(addr, capture_regs_pkg::pll_fraction_high_offset)) begin
                frac_hi_reg <= wdata[7:0];                 // [RULE_07]
            end
            if (hit(addr, capture_regs_pkg::pll_integer_dividers_offset)) begin
                pll_reg <= wdata[7:0];
            end
            if (hit(addr, capture_regs_pkg::interrupt_mask_offset)) begin
                mask_reg <= wdata[22:0];
            end
        end
    end

    // field counter: a write clears it and wins over a coincident count
    always_ff @(posedge clk) begin
        if (!rstn) begin
            count_reg <= capture_regs_pkg::byte_reset;     // [RULE_10]
        end else if (wr_en && hit(addr, capture_regs_pkg::field_transition_counter_offset)) begin
            count_reg <= capture_regs_pkg::byte_reset;     // [RULE_11]
        end else if (field_toggle && (ctl_reg[3:0] != 4'h0)) begin
            count_reg <= count_reg + 8'h01;                // [RULE_10]
        end
    end

    // status: a new event beats a write-one clear in the same cycle
    always_comb begin
        stat_next = stat_reg;
        if (wr_en && hit(addr, capture_regs_pkg::interrupt_status_offset)) begin
            stat_next = stat_next & ~wdata[22:0];          // [RULE_12]
        end
        stat_next = (stat_next | ev_vec) & capture_regs_pkg::latched_bits;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            stat_reg <= '0;
        end else begin
            stat_reg <= stat_next;                         // [RULE_12]
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            instr_reg <= 4'h0;
        end else begin
            instr_reg <= (instr_reg | instr_set) & ~instr_clear; // [RULE_13]
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ack_reg <= 1'b0;
        end else if (i2c_ok) begin
            ack_reg <= 1'b1;                               // [RULE_14]
        end else if (ev.i2c_done) begin
            ack_reg <= 1'b0;                               // [RULE_14]
        end
    end

    // the parity halt has priority so a stray enable cannot restart dma
    always_ff @(posedge clk) begin
        if (!rstn) begin
            dma_reg <= 1'b0;
        end else if (fetch_parity || dma_clear_enable) begin
            dma_reg <= 1'b0;                               // [RULE_19]
        end else if (dma_set_enable) begin
            dma_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata  <= '0;
            rvalid <= 1'b0;
        end else begin
            rvalid <= rd_en;
            rdata  <= '0;                                  // [RULE_25]
            if (rd_en) begin
                case (addr)
                    capture_regs_pkg::capture_control_offset: begin
                        rdata[4:0] <= ctl_reg;
                    end
                    capture_regs_pkg::vbi_length_low_offset: begin
                        rdata[7:0] <= len_lo_reg;
                    end
                    capture_regs_pkg::vbi_length_high_delay_offset: begin
                        rdata[7:0] <= len_hi_reg;
                    end
                    capture_regs_pkg::field_transition_counter_offset: begin
                        rdata[7:0] <= count_reg;
                    end
                    capture_regs_pkg::pll_fraction_low_offset: begin
                        rdata[7:0] <= frac_lo_reg;
                    end
                    capture_regs_pkg::pll_fraction_high_offset: begin
                        rdata[7:0] <= frac_hi_reg;
                    end
                    capture_regs_pkg::pll_integer_dividers_offset: begin
                        rdata[7:0] <= pll_reg;
                    end
                    capture_regs_pkg::interrupt_status_offset: begin
                        rdata[22:0] <= stat_reg;
                        rdata[capture_regs_pkg::field_bit] <= cur_field_even; // [RULE_15]
                        rdata[capture_regs_pkg::ack_bit] <= ack_reg;          // [RULE_14]
                        rdata[capture_regs_pkg::dma_en_bit] <= dma_reg;       // [RULE_13]
                        rdata[31:capture_regs_pkg::instr_lo_bit] <= instr_reg; // [RULE_13]
                    end
                    capture_regs_pkg::interrupt_mask_offset: begin
                        rdata[22:0] <= mask_reg;
                    end
                    default: begin
                        rdata <= '0;
                    end
                endcase
            end
        end
    end

    // decoded settings for the capture path and pll
    always_comb begin
        cfg.dither_full_frame     = ctl_reg[4];            // [RULE_01]
        cfg.blank_capture_odd_en  = ctl_reg[3];
        cfg.blank_capture_even_en = ctl_reg[2];
        cfg.capture_odd_en        = ctl_reg[1];
        cfg.capture_even_en       = ctl_reg[0];
        cfg.blank_length          = {len_hi_reg[0], len_lo_reg}; // [RULE_04]
        cfg.blank_line_delay      = len_hi_reg[7:2];       // [RULE_05]
        cfg.frame_region_extend   = len_hi_reg[1];         // [RULE_06]
        cfg.pll_fraction          = {frac_hi_reg, frac_lo_reg}; // [RULE_07]
        cfg.pll_integer           = pll_reg[5:0];
        cfg.pll_sleep             = (pll_reg[5:0] == capture_regs_pkg::pll_sleep_value); // [RULE_08]
        cfg.pll_post_div_four     = pll_reg[6];            // [RULE_09]
        cfg.pll_pre_div_two       = pll_reg[7];            // [RULE_09]
    end

    assign blank_write_ok = cur_field_even ? ctl_reg[2] : ctl_reg[3]; // [RULE_02]
    assign video_write_ok = cur_field_even ? ctl_reg[0] : ctl_reg[1]; // [RULE_03]
    assign dma_program_enable = dma_reg;
    assign irq_n = ~|(stat_reg & mask_reg);                // [RULE_24]

    a_count_clear: assert property (@(posedge clk) disable iff (!rstn) // [RULE_11]
        wr_en && hit(addr, capture_regs_pkg::field_transition_counter_offset)
        |=> count_reg == 8'h00)
        else $error("counter not cleared by write");

    a_count_step: assert property (@(posedge clk) disable iff (!rstn) // [RULE_10]
        field_toggle && ctl_reg[3:0] != 4'h0 && !wr_en
        |=> count_reg == $past(count_reg) + 8'h01)
        else $error("counter did not advance");

    a_count_hold: assert property (@(posedge clk) disable iff (!rstn) // [RULE_10]
        !field_toggle && !wr_en |=> $stable(count_reg))
        else $error("counter moved without transition");

    a_event_wins: assert property (@(posedge clk) disable iff (!rstn) // [RULE_12]
        ev.sync_error |=> stat_reg[19])
        else $error("sync error event lost");

    a_clear_one: assert property (@(posedge clk) disable iff (!rstn) // [RULE_12]
        wr_en && hit(addr, capture_regs_pkg::interrupt_status_offset) && wdata[17]
        && !ev.bus_abort |=> !stat_reg[17])
        else $error("abort flag not cleared");

    a_clear_zero: assert property (@(posedge clk) disable iff (!rstn) // [RULE_12]
        stat_reg[8] && !(wr_en && hit(addr, capture_regs_pkg::interrupt_status_offset)
        && wdata[8]) |=> stat_reg[8])
        else $error("i2c flag dropped");

    a_parity_halt: assert property (@(posedge clk) disable iff (!rstn) // [RULE_19]
        ev.instr_parity && parity_resp_en |=> !dma_reg && stat_reg[16])
        else $error("fetch parity did not halt dma");

    a_parity_gated: assert property (@(posedge clk) disable iff (!rstn) // [RULE_19]
        !stat_reg[16] && ev.instr_parity && !parity_resp_en |=> !stat_reg[16])
        else $error("fetch parity latched without response");

    a_irq_level: assert property (@(posedge clk) disable iff (!rstn) // [RULE_24]
        (stat_reg & mask_reg) != 23'h0 |-> !irq_n)
        else $error("interrupt not asserted");

    a_ack_nack: assert property (@(posedge clk) disable iff (!rstn) // [RULE_14]
        ev.i2c_done && !i2c_ok |=> !ack_reg)
        else $error("ack not cleared on nack");

    a_pll_sleep: assert property (@(posedge clk) disable iff (!rstn) // [RULE_08]
        wr_en && hit(addr, capture_regs_pkg::pll_integer_dividers_offset)
        && wdata[5:0] == 6'h00 |=> cfg.pll_sleep)
        else $error("pll not asleep at zero");

    a_pll_awake: assert property (@(posedge clk) disable iff (!rstn) // [RULE_08]
        pll_reg[5:0] != capture_regs_pkg::pll_sleep_value |-> !cfg.pll_sleep)
        else $error("pll asleep with nonzero integer");

    a_every_event: assert property (@(posedge clk) disable iff (!rstn) // [RULE_23]
        ev_vec != 23'h0 |=> (stat_reg & $past(ev_vec)) == $past(ev_vec))
        else $error("event not latched");

    a_stat_hold: assert property (@(posedge clk) disable iff (!rstn) // [RULE_12]
        ev_vec == 23'h0 && !(wr_en && hit(addr, capture_regs_pkg::interrupt_status_offset))
        |=> stat_reg == $past(stat_reg))
        else $error("status moved without event or clear");

    a_bus_parity: assert property (@(posedge clk) disable iff (!rstn) // [RULE_20]
        ev.bus_parity |=> stat_reg[15])
        else $error("bus parity not latched");

    a_abort_latch: assert property (@(posedge clk) disable iff (!rstn) // [RULE_18]
        ev.bus_abort |=> stat_reg[17])
        else $error("abort not latched");

    a_ctl_reserved: assert property (@(posedge clk) disable iff (!rstn) // [RULE_25]
        rd_en && hit(addr, capture_regs_pkg::capture_control_offset)
        |=> rdata[31:5] == 27'h0)
        else $error("control reserved bits not zero");

    a_stat_reserved: assert property (@(posedge clk) disable iff (!rstn) // [RULE_25]
        rd_en && hit(addr, capture_regs_pkg::interrupt_status_offset)
        |=> rdata[23:20] == 4'h0 && !rdata[26] && !rdata[10] && rdata[7:6] == 2'b00)
        else $error("status reserved bits not zero");

    a_mask_reserved: assert property (@(posedge clk) disable iff (!rstn) // [RULE_25]
        rd_en && hit(addr, capture_regs_pkg::interrupt_mask_offset)
        |=> rdata[31:23] == 9'h000)
        else $error("mask reserved bits not zero");

    a_idle_zero: assert property (@(posedge clk) disable iff (!rstn) // [RULE_25]
        !rd_en
        |=> rdata == 32'h0 && !rvalid)
        else $error("read port not idle");

    a_field_status: assert property (@(posedge clk) disable iff (!rstn) // [RULE_15]
        rd_en && hit(addr, capture_regs_pkg::interrupt_status_offset)
        |=> rvalid && rdata[capture_regs_pkg::field_bit] == $past(cur_field_even))
        else $error("field indicator wrong");

    a_ack_set: assert property (@(posedge clk) disable iff (!rstn) // [RULE_14]
        i2c_ok |=> ack_reg)
        else $error("ack not set on success");

    a_instr_clear: assert property (@(posedge clk) disable iff (!rstn) // [RULE_13]
        instr_clear != 4'h0
        |=> (instr_reg & $past(instr_clear)) == 4'h0)
        else $error("instruction status not reset");

    a_instr_set: assert property (@(posedge clk) disable iff (!rstn) // [RULE_13]
        instr_set != 4'h0 && instr_clear == 4'h0
        |=> (instr_reg & $past(instr_set)) == $past(instr_set))
        else $error("instruction status not set");

    a_blank_gate: assert property (@(posedge clk) disable iff (!rstn) // [RULE_02]
        (cur_field_even ? !ctl_reg[2] : !ctl_reg[3])
        |-> !blank_write_ok)
        else $error("blanking capture open while disabled");

    a_video_gate: assert property (@(posedge clk) disable iff (!rstn) // [RULE_03]
        (cur_field_even ? !ctl_reg[0] : !ctl_reg[1])
        |-> !video_write_ok)
        else $error("video write open while disabled");

endmodule : capture_regs

// ===== logic/capture_regs_pkg.sv
// package for the capture configuration and status register bank
// assumes a simple synchronous register port driven by the host bus logic
package capture_regs_pkg;

    localparam logic [8:0]  capture_control_offset    = 9'h0dc;
    localparam logic [8:0]  vbi_length_low_offset     = 9'h0e0;
    localparam logic [8:0]  vbi_length_high_delay_offset = 9'h0e4;
    localparam logic [8:0]  field_transition_counter_offset = 9'h0e8;
    localparam logic [8:0]  pll_fraction_low_offset   = 9'h0f0;
    localparam logic [8:0]  pll_fraction_high_offset  = 9'h0f4;
    localparam logic [8:0]  pll_integer_dividers_offset = 9'h0f8;
    localparam logic [8:0]  interrupt_status_offset   = 9'h100;
    localparam logic [8:0]  interrupt_mask_offset     = 9'h104;

    localparam logic [7:0]  byte_reset                = 8'h00;
    localparam logic [22:0] mask_reset                = 23'h000000;
    localparam logic [22:0] latched_bits              = 23'h0ffb3f;
    localparam int          ctl_used_bits             = 5;
    localparam int          field_bit                 = 24;
    localparam int          ack_bit                   = 25;
    localparam int          dma_en_bit                = 27;
    localparam int          instr_lo_bit              = 28;
    localparam logic [5:0]  pll_sleep_value           = 6'h00;

    typedef struct packed {
        logic sync_error;       // bit 19
        logic opcode_error;     // bit 18
        logic bus_abort;        // bit 17
        logic instr_parity;     // bit 16
        logic bus_parity;       // bit 15
        logic stream_resync;    // bit 14
        logic overrun_latency;  // bit 13
        logic overrun_drop;     // bit 12
        logic instr_irq;        // bit 11
        logic gp_pin;           // bit 9
        logic i2c_done;         // bit 8
        logic video_presence;   // bit 5
        logic change_flag_a;    // bit 4
        logic conv_overflow;    // bit 3
        logic new_line;         // bit 2
        logic field_change;     // bit 1
        logic format_change;    // bit 0
    } event_type;

    typedef struct packed {
        logic       dither_full_frame;
        logic       blank_capture_odd_en;
        logic       blank_capture_even_en;
        logic       capture_odd_en;
        logic       capture_even_en;
        logic [8:0] blank_length;
        logic [5:0] blank_line_delay;
        logic       frame_region_extend;
        logic [15:0] pll_fraction;
        logic [5:0] pll_integer;
        logic       pll_sleep;
        logic       pll_post_div_four;
        logic       pll_pre_div_two;
    } config_type;

endpackage : capture_regs_pkg
